// ---- logic/cws_sequencer.sv ----
/*
  Wake-up sequencer: after configuration, steps four phases and releases the
  core set/reset, the memory write guard, the I/O hold-off and, with waiting off, the
  completion pin per the selected sequence. Assumes the user clock, test clock and
  config port clock are supplied and the select inputs are stable during wake-up.
*/
`timescale 1ns/1ps
`default_nettype none

module cws_sequencer
  import cws_pkg::*;
(
  // Clocks and reset
  input wire logic clock,
  input wire logic test_clock,
  input wire logic config_port_clock,
  input wire logic rst_b,
  // Options
  input wire logic use_user_clock,
  input wire logic loaded_by_jtag,
  input wire logic external_completion_wait,
  input wire logic completion_pin_open_drain,
  input wire logic [4:0] sequence_select,
  input wire logic sequence_use_default,
  // Configuration status
  input wire logic config_done_flag,
  input wire logic config_error,
  // Completion pin
  input wire logic completion_pin_in,
  output logic completion_pin_out,
  output logic completion_pin_oe,
  // Internal controls
  output logic core_set_reset,
  output logic memory_write_guard,
  output logic io_output_hold_off,
  // Status
  output logic wake_active,
  output logic wake_complete,
  output logic [4:0] active_sequence
);

  // ------------------------------------------------------------------
  // Clock selection
  // ------------------------------------------------------------------
  logic wake_clock;

  cws_clock_select u_clock_select
  (
    .test_clock(test_clock),
    .config_port_clock(config_port_clock),
    .user_clock(clock),
    .use_user_clock(use_user_clock),
    .loaded_by_jtag(loaded_by_jtag),
    .wake_clock(wake_clock)
  );

  // ------------------------------------------------------------------
  // Sequence choice
  // ------------------------------------------------------------------
  logic seq_legal;
  logic [4:0] seq_next;

  always_comb
  begin
    if (external_completion_wait)
      seq_legal = (sequence_select >= CWS_SEQ_MIN_WAIT) &&
                  (sequence_select <= CWS_SEQ_MAX_WAIT);
    else
      seq_legal = (sequence_select >= CWS_SEQ_MIN_NOWAIT) &&
                  (sequence_select <= CWS_SEQ_MAX_NOWAIT);
    // An out-of-range choice falls back to the default rather than waking
    // with an undefined order.
    if (seq_legal && !sequence_use_default)
      seq_next = sequence_select;
    else if (external_completion_wait)
      seq_next = CWS_SEQ_DEF_WAIT;
    else
      seq_next = CWS_SEQ_DEF_NOWAIT;
  end

  // ------------------------------------------------------------------
  // Phase state machine
  // ------------------------------------------------------------------
  // Wake-up runs once per reset. The sequencer leaves configuration on the
  // first wake-clock edge that sees the start condition and never returns,
  // so a late glitch on the done flag cannot restart a finished wake-up.
  typedef enum logic [1:0] {CWS_CONFIG, CWS_RUN, CWS_USER} cws_state_e;

  cws_state_e state_reg;
  logic [1:0] phase_reg;
  logic [4:0] seq_reg;
  logic start_ok;

  // The pin is only read with waiting on; a low pin from another device
  // postpones wake-up while letting configuration finish.
  assign start_ok = config_done_flag && !config_error &&
                    (!external_completion_wait || completion_pin_in);

  always_ff @(posedge wake_clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= CWS_CONFIG;
      phase_reg <= 2'h0;
    end
    else
    begin
      unique case (state_reg)
        CWS_CONFIG:
        begin
          if (start_ok)
          begin
            state_reg <= CWS_RUN;
            phase_reg <= 2'h0;
          end
        end
        CWS_RUN:
        begin
          if (phase_reg == CWS_LAST_PHASE)
            state_reg <= CWS_USER;
          else
            phase_reg <= phase_reg + 2'h1;
        end
        CWS_USER:
        begin
          state_reg <= CWS_USER;
        end
      endcase
    end
  end

  // The choice is taken on every edge in configuration, so a select that
  // settles late still counts; once stepping starts it is frozen, and a
  // change of the select cannot reorder a wake-up that is under way.
  always_ff @(posedge wake_clock or negedge rst_b)
  begin
    if (!rst_b)
      seq_reg <= CWS_SEQ_DEF_NOWAIT;
    else if (state_reg == CWS_CONFIG)
      seq_reg <= seq_next;
  end

  // ------------------------------------------------------------------
  // Transition outputs
  // ------------------------------------------------------------------
  // Each control moves once, at the edge that closes its phase, and then
  // stays released until the next reset.
  logic [7:0] entry;
  logic hit_done;
  logic hit_hold;
  logic hit_guard;
  logic hit_csr;

  assign entry = CWS_TABLE[seq_reg];
  assign hit_done = (state_reg == CWS_RUN) &&
                    (entry[CWS_F_DONE +: 2] == phase_reg);
  assign hit_hold = (state_reg == CWS_RUN) && (entry[CWS_F_HOLD +: 2] == phase_reg);
  assign hit_guard = (state_reg == CWS_RUN) && (entry[CWS_F_GUARD +: 2] == phase_reg);
  assign hit_csr = (state_reg == CWS_RUN) && (entry[CWS_F_CSR +: 2] == phase_reg);

  logic done_reg;

  always_ff @(posedge wake_clock or negedge rst_b)
  begin
    if (!rst_b)
      core_set_reset <= 1'b0;
    else if (hit_csr)
      core_set_reset <= 1'b1;
  end

  always_ff @(posedge wake_clock or negedge rst_b)
  begin
    if (!rst_b)
      memory_write_guard <= 1'b0;
    else if (hit_guard)
      memory_write_guard <= 1'b1;
  end

  always_ff @(posedge wake_clock or negedge rst_b)
  begin
    if (!rst_b)
      io_output_hold_off <= 1'b1;
    else if (hit_hold)
      io_output_hold_off <= 1'b0;
  end

  always_ff @(posedge wake_clock or negedge rst_b)
  begin
    if (!rst_b)
      done_reg <= 1'b0;
    else if (hit_done && !config_error)
      done_reg <= 1'b1;
  end

  // ------------------------------------------------------------------
  // Completion pin driver
  // ------------------------------------------------------------------
  // With waiting on, the device must let go of its own pin as soon as
  // loading has ended cleanly; otherwise its own pull-down would hold the
  // shared line low and wake-up could never start. The line then reads
  // high only once every chained device has let go, so the phase given to
  // the pin in the waiting sequences does not change when it is released, whatever the drive type.
  logic pin_release;

  assign pin_release = done_reg || (external_completion_wait &&
                       config_done_flag && !config_error);

  // Open-drain only pulls low, so a chain wired together reads high only
  // when every device has released it.
  assign completion_pin_out = pin_release && !completion_pin_open_drain;
  assign completion_pin_oe = completion_pin_open_drain ? !pin_release : 1'b1;

  // ------------------------------------------------------------------
  // Status
  // ------------------------------------------------------------------
  assign wake_active = (state_reg == CWS_RUN);
  assign wake_complete = (state_reg == CWS_USER);
  assign active_sequence = seq_reg;

endmodule // cws_sequencer

`default_nettype wire

// ---- include/cws_pkg.sv ----
/*
  Constants for the configuration wake-up sequencer: phase encoding, sequence
  limits and defaults, and the per-sequence phase table.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cws_pkg;

  // ------------------------------------------------------------------
  // Sequence numbering
  // ------------------------------------------------------------------
  localparam logic [4:0] CWS_SEQ_DEF_NOWAIT = 5'h15;
  localparam logic [4:0] CWS_SEQ_DEF_WAIT = 5'h04;
  localparam logic [4:0] CWS_SEQ_MIN_NOWAIT = 5'h08;
  localparam logic [4:0] CWS_SEQ_MAX_NOWAIT = 5'h19;
  localparam logic [4:0] CWS_SEQ_MIN_WAIT = 5'h01;
  localparam logic [4:0] CWS_SEQ_MAX_WAIT = 5'h07;

  // ------------------------------------------------------------------
  // Phase table
  // ------------------------------------------------------------------
  // Entry packs four 2-bit phases: [7:6] completion, [5:4] hold-off,
  // [3:2] write guard, [1:0] set/reset.
  localparam int CWS_F_DONE = 6;
  localparam int CWS_F_HOLD = 4;
  localparam int CWS_F_GUARD = 2;
  localparam int CWS_F_CSR = 0;
  localparam logic [1:0] CWS_LAST_PHASE = 2'h3;

  localparam logic [7:0] CWS_TABLE [1:25] = '{
    8'h15, 8'h2A, 8'h3F, 8'h1A, 8'h1F, 8'h1B, 8'h1E,
    8'h6A, 8'h7F, 8'h7A, 8'h6F, 8'hBF, 8'h95, 8'h9F,
    8'h97, 8'hB7, 8'hB5, 8'h9D, 8'hEA, 8'hD5, 8'hDA,
    8'hD6, 8'hE6, 8'hE5, 8'hD9
  };

endpackage

// ---- logic/cws_clock_select.sv ----
/*
  Wake-up clock selector: picks the test clock, the config port clock or a
  user design clock. Assumes selects are static once loading has finished.
*/
`timescale 1ns/1ps
`default_nettype none

module cws_clock_select
(
  // Clock candidates
  input wire logic test_clock,
  input wire logic config_port_clock,
  input wire logic user_clock,
  // Selection
  input wire logic use_user_clock,
  input wire logic loaded_by_jtag,
  // Result
  output logic wake_clock
);

  // Static selects only; a live switch could glitch the sequencer clock.
  always_comb
  begin
    if (use_user_clock)
      wake_clock = user_clock;
    else if (loaded_by_jtag)
      wake_clock = test_clock;
    else
      wake_clock = config_port_clock;
  end

endmodule // cws_clock_select

`default_nettype wire

// ---- dv/cws_sequencer_chk.sv ----
/* Checker bound to the wake-up sequencer top.
   Assumes wake-up timing is judged on the user clock. */
`timescale 1ns/1ps
`default_nettype none
module cws_sequencer_chk
(
  // Clock, reset and options
  input wire logic clock,
  input wire logic rst_b,
  input wire logic use_user_clock,
  input wire logic external_completion_wait,
  input wire logic completion_pin_open_drain,
  input wire logic config_done_flag,
  input wire logic config_error,
  // Pin and controls
  input wire logic completion_pin_in,
  input wire logic completion_pin_out,
  input wire logic completion_pin_oe,
  input wire logic core_set_reset,
  input wire logic memory_write_guard,
  input wire logic io_output_hold_off,
  input wire logic wake_active,
  input wire logic wake_complete,
  input wire logic [4:0] active_sequence
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic cfg, go, idle;
  assign cfg = !wake_active && !wake_complete;
  // Start timing only holds when the user clock is the wake clock.
  assign go = use_user_clock && cfg;
  assign idle = go && config_done_flag && !config_error;
  sequence s_run; wake_active [*4]; endsequence
  sequence s_end; wake_complete && !wake_active; endsequence
  AST_START: assert property (idle && !external_completion_wait |=> wake_active)
    else $error("wake-up did not start");
  AST_WAIT: assert property (go && external_completion_wait && !completion_pin_in
    |=> !wake_active) else $error("start while pin held low");
  AST_PHASES: assert property ($rose(wake_active) |-> s_run ##1 s_end)
    else $error("phase count wrong");
  AST_HELD: assert property (cfg |-> !core_set_reset && !memory_write_guard
    && io_output_hold_off && (config_done_flag || completion_pin_oe)
    && (!completion_pin_out || config_done_flag && external_completion_wait))
    else $error("released in configuration");
  AST_STANDS: assert property (wake_complete |-> core_set_reset && memory_write_guard
    && !io_output_hold_off ##1 wake_complete) else $error("control not released");
  AST_OD: assert property (completion_pin_open_drain ? !completion_pin_out : completion_pin_oe)
    else $error("pin drive type wrong");
  AST_ERR: assert property (config_error && !completion_pin_out ##1 config_error
    |=> !completion_pin_out) else $error("pin rose under error");
  AST_SEQ: assert property (go |=> external_completion_wait ?
    active_sequence inside {[1:7]} : active_sequence inside {[8:25]}) else $error("bad sequence");
endmodule // cws_sequencer_chk
bind cws_sequencer cws_sequencer_chk chk (.*);
`default_nettype wire

// ---- dv/cws_peer_model.sv ----
/* Another chained device sharing the completion line.
   Assumes a pull-up on the line; any low drive wins. */
`timescale 1ns/1ps
`default_nettype none
module cws_peer_model
(
  // Peer and sequencer drive
  input wire logic peer_hold,
  input wire logic completion_pin_out,
  input wire logic completion_pin_oe,
  // Resolved line
  output logic line
);
  // An open-drain peer can only pull low, so it may hold off wake-up for any time.
  assign line = !(peer_hold || (completion_pin_oe && !completion_pin_out));
endmodule // cws_peer_model
`default_nettype wire

// ---- dv/test_cws_sequencer.sv ----
/* Self-checking bench for the wake-up sequencer with a chained peer.
   Assumes the checker and the peer model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_cws_sequencer;
  logic clock = 1'b0;
  logic rst_b, use_user_clock, loaded_by_jtag, external_completion_wait, tck_en, cpc_en;
  logic completion_pin_open_drain, sequence_use_default, config_done_flag, config_error;
  logic peer_hold, line, completion_pin_out, completion_pin_oe, core_set_reset;
  logic memory_write_guard, io_output_hold_off, wake_active, wake_complete;
  logic test_clock, config_port_clock;
  logic [4:0] sequence_select, active_sequence;
  logic [11:0] row;
  int err_count = 0;
  int cmp_count = 0;
  // Phases: [7:6] pin, [5:4] hold-off, [3:2] guard, [1:0] set/reset.
  logic [7:0] ph_tab [1:25] = '{8'h15, 8'h2A, 8'h3F, 8'h1A, 8'h1F, 8'h1B, 8'h1E, 8'h6A, 8'h7F,
    8'h7A, 8'h6F, 8'hBF, 8'h95, 8'h9F, 8'h97, 8'hB7, 8'hB5, 8'h9D, 8'hEA, 8'hD5, 8'hDA,
    8'hD6, 8'hE6, 8'hE5, 8'hD9};
  // Rows: select, wait, use default, sequence expected.
  logic [11:0] rows [7] = '{12'h1B5, 12'hAE4, 12'h295, 12'h015, 12'hD15, 12'h444, 12'h044};
  // Gating keeps the external clocks glitch free and in step with the bench clock.
  assign test_clock = clock & tck_en;
  assign config_port_clock = clock & cpc_en;
  always #20 clock = ~clock;
  cws_peer_model peer (.*);
  cws_sequencer dut (.completion_pin_in(line), .*);
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("Compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic setup(input logic [4:0] sel, input logic wt, dft, input logic [1:0] src);
    rst_b = 1'b0;
    use_user_clock = src == 2'h0;
    loaded_by_jtag = src == 2'h1;
    tck_en = src == 2'h1;
    cpc_en = src == 2'h2;
    external_completion_wait = wt;
    completion_pin_open_drain = wt;
    sequence_select = sel;
    sequence_use_default = dft;
    config_done_flag = 1'b1;
    config_error = 1'b0;
    repeat (12) @(negedge clock);
  endtask
  task automatic run(input logic [4:0] sel, input logic wt, dft, input logic [4:0] exp,
    input logic [1:0] src, input int hold);
    logic [7:0] ph;
    logic [3:0] g, e;
    ph = ph_tab[exp];
    peer_hold = hold > 0;
    setup(sel, wt, dft, src);
    rst_b = 1'b1;
    repeat (hold)
    begin
      @(negedge clock);
      chk({5'h00, wake_active}, 6'h00);
    end
    peer_hold = 1'b0;
    for (int k = 0; k < 5; k++)
    begin
      @(negedge clock);
      g = {wt ? line : completion_pin_out, memory_write_guard, core_set_reset, !io_output_hold_off};
      e = {wt || ph[7:6] < k, ph[3:2] < k, ph[1:0] < k, ph[5:4] < k};
      chk({2'h0, g}, {2'h0, e});
    end
    chk({wake_complete, active_sequence}, {1'b1, exp});
    $display("Sequence %0d done at %0t", exp, $time);
  endtask
  initial
  begin
    for (int i = 1; i < 26; i++)
      run(i[4:0], i < 8, 1'b0, i[4:0], 2'h0, 0);
    foreach (rows[r])
    begin
      row = rows[r];
      run(row[11:7], row[6], row[5], row[4:0], 2'h0, 0);
    end
    run(5'h15, 1'b0, 1'b0, 5'h15, 2'h1, 0);
    run(5'h04, 1'b1, 1'b0, 5'h04, 2'h2, 0);
    run(5'h04, 1'b1, 1'b0, 5'h04, 2'h0, 6);
    setup(5'h04, 1'b1, 1'b0, 2'h0);
    config_done_flag = 1'b0;
    rst_b = 1'b1;
    repeat (4) @(negedge clock);
    chk({4'h0, wake_active, line}, 6'h00);
    config_done_flag = 1'b1;
    @(negedge clock);
    chk({4'h0, wake_active, line}, 6'h03);
    repeat (5) @(negedge clock);
    chk({4'h0, wake_complete, core_set_reset}, 6'h03);
    $display("Done flag start checked at %0t", $time);
    setup(5'h15, 1'b0, 1'b0, 2'h1);
    tck_en = 1'b0;
    cpc_en = 1'b1;
    rst_b = 1'b1;
    repeat (6) @(negedge clock);
    chk({5'h00, wake_active}, 6'h00);
    $display("Idle wake clock checked at %0t", $time);
    setup(5'h15, 1'b0, 1'b0, 2'h0);
    config_error = 1'b1;
    chk({io_output_hold_off, active_sequence}, 6'h35);
    rst_b = 1'b1;
    repeat (8) @(negedge clock);
    chk({wake_active, completion_pin_out, core_set_reset, 3'h0}, 6'h00);
    config_error = 1'b0;
    repeat (6) @(negedge clock);
    chk({wake_complete, completion_pin_out, 4'h0}, 6'h30);
    $display("Error hold checked at %0t", $time);
    complete_run;
  end
  // About 40 runs of 20 cycles each at 40 ns; twelve and a half times that before giving up.
  initial
  begin
    #400000;
    err_count++;
    complete_run;
  end
endmodule // test_cws_sequencer
`default_nettype wire
